// ---- clk_fanout_pkg.sv ----
// Package with the register map and field layout of the fan-out buffer control block
package clk_fanout_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_OUTPUTS = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int SEL_W = 2;
	localparam int DSTATE_W = 2;
	localparam int OUTS_PER_BYTE = 4;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] REF_SRC_OFS = 8'h04;
	localparam logic [7:0] DIS_LOW_OFS = 8'h05;
	localparam logic [7:0] DIS_MID_OFS = 8'h06;
	localparam logic [7:0] DIS_HIGH_OFS = 8'h07;
	localparam logic [7:0] ON_LOW_OFS = 8'h08;
	localparam logic [7:0] ON_HIGH_OFS = 8'h09;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] DIS_RST = 8'h00;
	localparam logic [7:0] ON_RST = 8'h00;
	localparam logic [1:0] SEL_RST = 2'h0;
	localparam logic XTAL_RUN_RST = 1'b1;
	// ----------------------------------------
	// Field encodings
	// ----------------------------------------
	localparam logic [1:0] SEL_DIFF0 = 2'h0;
	localparam logic [1:0] SEL_DIFF1 = 2'h1;
	localparam logic [1:0] SEL_XTAL = 2'h2;
	localparam logic [1:0] SEL_BYPASS = 2'h3;
	localparam logic [1:0] DS_BOTH_LOW = 2'h0;
	localparam logic [1:0] DS_DRIVE_LOW = 2'h1;
	typedef enum logic [1:0] {
		DRV_OFF_LOW,
		DRV_OFF_SPLIT,
		DRV_OFF_HIZ,
		DRV_ACTIVE
	} drive_mode_e;
endpackage

// ---- clk_fanout_regs.sv ----
// Register bank and per-output drive control of the clock fan-out buffer
//
// Operation
// - Source 00/01 picks differential pair 0/1
// - Source 10 uses crystal oscillator or overdrive
// - Source 11 bypass, crystal amplifier kept off
// - Disabled 00 both low, 01 true low
// - Disabled codes 10 and 11 give high impedance
// - Disabled level applies only while enable low
// - Four disabled fields per byte, offsets 05-07
// - Outputs 8-11 byte only on twelve-output variant
// - Enable bytes 08-09, one bit each, reset zero
// - Enabled output runs low-power HCSL clock
// - Normal-run crystal runs only in mode 10
// - Source reset value from programmable defaults
`timescale 1ns/1ps
`default_nettype none
module clk_fanout_regs #(
	parameter bit TWELVE_OUT = 1'b1
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// Register port (serial bus decoded outside)
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [clk_fanout_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [clk_fanout_pkg::DATA_W-1:0] reg_wdata_i,
	output logic [clk_fanout_pkg::DATA_W-1:0] reg_rdata_o,
	// Programmable defaults, sampled after reset release
	input wire logic [clk_fanout_pkg::SEL_W-1:0] otp_ref_sel_i,
	input wire logic otp_xtal_run_i,
	// Reference clocks (already in core domain as gating clocks)
	input wire logic diff_ref0_true_i,
	input wire logic diff_ref1_true_i,
	input wire logic crystal_in_pin_i,
	// Analog controls
	output logic xtal_osc_en_o,
	output logic xtal_amp_en_o,
	output logic [clk_fanout_pkg::SEL_W-1:0] ref_mux_sel_o,
	// Clock outputs
	output logic [clk_fanout_pkg::NUM_OUTPUTS-1:0] clock_out_true_o,
	output logic [clk_fanout_pkg::NUM_OUTPUTS-1:0] clock_out_comp_o,
	output logic [clk_fanout_pkg::NUM_OUTPUTS-1:0] clock_out_oe_o,
	output logic [clk_fanout_pkg::NUM_OUTPUTS-1:0] low_power_diff_drive_o
);
	import clk_fanout_pkg::*;

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rst_meta_r;
	logic rst_n_r;
	logic otp_loaded_r;

	// Release is synchronised so every flop reset by rst_n_r leaves reset together
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [SEL_W-1:0] reference_source_register;
	logic xtal_normal_run_r;
	logic [DATA_W-1:0] disabled_level_reg_low;
	logic [DATA_W-1:0] disabled_level_reg_mid;
	logic [DATA_W-1:0] disabled_level_reg_high;
	logic [DATA_W-1:0] output_on_bits_low;
	logic [OUTS_PER_BYTE-1:0] output_on_bits_high;

	// Defaults are loaded by a clocked step after release, never from a port under reset
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			otp_loaded_r <= 1'b0;
			reference_source_register <= SEL_RST;
			xtal_normal_run_r <= XTAL_RUN_RST;
		end else if (!otp_loaded_r) begin
			otp_loaded_r <= 1'b1;
			reference_source_register <= otp_ref_sel_i;
			xtal_normal_run_r <= otp_xtal_run_i;
		end else if (reg_wr_i && reg_addr_i == REF_SRC_OFS) begin
			// Upper bits dropped on write
			reference_source_register <= reg_wdata_i[SEL_W-1:0];
		end
	end

	// Disabled-level and enable registers
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			disabled_level_reg_low <= DIS_RST;
			disabled_level_reg_mid <= DIS_RST;
			disabled_level_reg_high <= DIS_RST;
			output_on_bits_low <= ON_RST;
			output_on_bits_high <= ON_RST[OUTS_PER_BYTE-1:0];
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				DIS_LOW_OFS: disabled_level_reg_low <= reg_wdata_i;
				DIS_MID_OFS: disabled_level_reg_mid <= reg_wdata_i;
				DIS_HIGH_OFS: begin
					if (TWELVE_OUT) begin
						disabled_level_reg_high <= reg_wdata_i;
					end
				end
				ON_LOW_OFS: output_on_bits_low <= reg_wdata_i;
				ON_HIGH_OFS: begin
					if (TWELVE_OUT) begin
						output_on_bits_high <= reg_wdata_i[OUTS_PER_BYTE-1:0];
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [DATA_W-1:0] rdata_nxt;

	// Absent registers and unmapped offsets read zero
	always_comb begin
		rdata_nxt = 8'h00;
		case (reg_addr_i)
			REF_SRC_OFS: rdata_nxt = {6'h00, reference_source_register};
			DIS_LOW_OFS: rdata_nxt = disabled_level_reg_low;
			DIS_MID_OFS: rdata_nxt = disabled_level_reg_mid;
			DIS_HIGH_OFS: rdata_nxt = TWELVE_OUT ? disabled_level_reg_high : 8'h00;
			ON_LOW_OFS: rdata_nxt = output_on_bits_low;
			ON_HIGH_OFS: rdata_nxt = TWELVE_OUT ? {4'h0, output_on_bits_high} : 8'h00;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Read data registered one cycle after the strobe
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Reference selection and crystal control
	// ----------------------------------------
	logic ref_clk;

	// Mux of the selected reference
	always_comb begin
		case (reference_source_register)
			SEL_DIFF0: ref_clk = diff_ref0_true_i;
			SEL_DIFF1: ref_clk = diff_ref1_true_i;
			SEL_XTAL: ref_clk = crystal_in_pin_i;
			SEL_BYPASS: ref_clk = crystal_in_pin_i;
			default: ref_clk = diff_ref0_true_i;
		endcase
	end

	// Amplifier only off in bypass; normal-run limits the oscillator to crystal mode
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			xtal_osc_en_o <= 1'b0;
			xtal_amp_en_o <= 1'b0;
			ref_mux_sel_o <= SEL_RST;
		end else begin
			ref_mux_sel_o <= reference_source_register;
			xtal_amp_en_o <= reference_source_register != SEL_BYPASS;
			if (xtal_normal_run_r) begin
				xtal_osc_en_o <= reference_source_register == SEL_XTAL;
			end else begin
				xtal_osc_en_o <= reference_source_register != SEL_BYPASS;
			end
		end
	end

	// ----------------------------------------
	// Per-output drivers
	// ----------------------------------------
	logic [3*DATA_W-1:0] dis_all;
	logic [NUM_OUTPUTS-1:0] on_all;
	assign dis_all = {disabled_level_reg_high, disabled_level_reg_mid, disabled_level_reg_low};
	assign on_all = {output_on_bits_high, output_on_bits_low};

	genvar k;
	generate
		for (k = 0; k < NUM_OUTPUTS; k++) begin : g_out
			logic [DSTATE_W-1:0] code;
			logic on_r;
			drive_mode_e mode;
			assign code = dis_all[DSTATE_W*k +: DSTATE_W];

			// Enable retimed while the reference is low, so no runt pulse
			always_ff @(posedge core_clk_i or negedge rst_n_r) begin
				if (!rst_n_r) begin
					on_r <= 1'b0;
				end else if (!ref_clk) begin
					on_r <= on_all[k];
				end
			end

			// Field only matters while the output is off
			always_comb begin
				if (on_r) begin
					mode = DRV_ACTIVE;
				end else begin
					case (code)
						DS_BOTH_LOW: mode = DRV_OFF_LOW;
						DS_DRIVE_LOW: mode = DRV_OFF_SPLIT;
						default: mode = DRV_OFF_HIZ;
					endcase
				end
			end

			// Output legs all registered
			always_ff @(posedge core_clk_i or negedge rst_n_r) begin
				if (!rst_n_r) begin
					clock_out_true_o[k] <= 1'b0;
					clock_out_comp_o[k] <= 1'b0;
					clock_out_oe_o[k] <= 1'b1;
					low_power_diff_drive_o[k] <= 1'b0;
				end else begin
					case (mode)
						DRV_ACTIVE: begin
							clock_out_true_o[k] <= ref_clk;
							clock_out_comp_o[k] <= ~ref_clk;
							clock_out_oe_o[k] <= 1'b1;
							low_power_diff_drive_o[k] <= 1'b1;
						end
						DRV_OFF_SPLIT: begin
							clock_out_true_o[k] <= 1'b0;
							clock_out_comp_o[k] <= 1'b1;
							clock_out_oe_o[k] <= 1'b1;
							low_power_diff_drive_o[k] <= 1'b0;
						end
						DRV_OFF_HIZ: begin
							clock_out_true_o[k] <= 1'b0;
							clock_out_comp_o[k] <= 1'b0;
							clock_out_oe_o[k] <= 1'b0;
							low_power_diff_drive_o[k] <= 1'b0;
						end
						default: begin
							clock_out_true_o[k] <= 1'b0;
							clock_out_comp_o[k] <= 1'b0;
							clock_out_oe_o[k] <= 1'b1;
							low_power_diff_drive_o[k] <= 1'b0;
						end
					endcase
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ---- host_model.sv ----
// Host software model driving the register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Bus side
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o
);
	// ----
	// Register access
	// ----
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d; // Stale data never lingers
	endtask
	// Data is settled one cycle after the read edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(negedge clk_i);
		d = rdata_i;
	endtask
	// Level first, so a wrong level never shows on disable
	task automatic set_out(input logic [7:0] la, ld, ea, ed);
		wr(la, ld);
		wr(ea, ed);
	endtask
endmodule
`default_nettype wire

// ---- clk_fanout_regs_assertions.sv ----
// Port checker of the fan-out control block
`timescale 1ns/1ps
`default_nettype none
module clk_fanout_regs_assertions
	import clk_fanout_pkg::*;
(
	// Watched ports
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic otp_xtal_run_i,
	input wire logic diff_ref0_true_i,
	input wire logic xtal_osc_en_o,
	input wire logic xtal_amp_en_o,
	input wire logic [1:0] ref_mux_sel_o,
	input wire logic [11:0] clock_out_true_o,
	input wire logic [11:0] clock_out_comp_o,
	input wire logic [11:0] clock_out_oe_o,
	input wire logic [11:0] low_power_diff_drive_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// ----
	// Assertions
	// ----
	// Two-cycle guards skip the edge where drive state itself switches
	a_follow_pair0: assert property (
		low_power_diff_drive_o[0] && $past(low_power_diff_drive_o[0]) && $stable(ref_mux_sel_o)
		&& ref_mux_sel_o == SEL_DIFF0 |-> clock_out_true_o[0] == $past(diff_ref0_true_i))
		else $error("leg not following pair 0");
	// Enable may only take hold while the selected reference sat low
	a_enable_at_low: assert property (
		$rose(low_power_diff_drive_o[0]) && ref_mux_sel_o == SEL_DIFF0 && $stable(ref_mux_sel_o)
		|-> !$past(diff_ref0_true_i, 2))
		else $error("enable applied while reference high");
	a_xtal_runs: assert property (
		(ref_mux_sel_o == SEL_XTAL)[*3] |-> xtal_osc_en_o && xtal_amp_en_o)
		else $error("crystal idle in crystal mode");
	a_bypass_amp_off: assert property (
		(ref_mux_sel_o == SEL_BYPASS)[*3] |-> !xtal_amp_en_o)
		else $error("amplifier on in bypass");
	a_osc_only_xtal: assert property (
		otp_xtal_run_i && (ref_mux_sel_o != SEL_XTAL)[*3] |-> !xtal_osc_en_o)
		else $error("oscillator on outside crystal mode");
	a_true_low_off: assert property (
		(~low_power_diff_drive_o & ~$past(low_power_diff_drive_o) & clock_out_oe_o
		& clock_out_true_o) == 12'h000)
		else $error("true leg high while disabled");
	a_active_driven: assert property (
		(low_power_diff_drive_o & $past(low_power_diff_drive_o) & ~clock_out_oe_o) == 12'h000)
		else $error("active output not driven");
	a_legs_differ: assert property (
		(low_power_diff_drive_o & $past(low_power_diff_drive_o)
		& ~(clock_out_true_o ^ clock_out_comp_o)) == 12'h000)
		else $error("active legs not complementary");
	a_src_upper_zero: assert property (
		reg_rd_i && reg_addr_i == REF_SRC_OFS |=> reg_rdata_o[7:2] == 6'h00)
		else $error("source upper bits not zero");
	a_enable_readback: assert property (
		reg_wr_i && reg_addr_i == ON_LOW_OFS ##2 reg_rd_i && reg_addr_i == ON_LOW_OFS
		|=> reg_rdata_o == $past(reg_wdata_i, 3))
		else $error("enable byte readback wrong");
	// Main scenarios
	c_clock_output_zero_on: cover property (low_power_diff_drive_o[0]);
	c_bypass: cover property (ref_mux_sel_o == SEL_BYPASS);
	c_clock_output_zero_hiz: cover property (!clock_out_oe_o[0]);
endmodule
bind clk_fanout_regs clk_fanout_regs_assertions u_chk (.core_clk_i, .arst_n_i, .reg_wr_i,
	.reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .otp_xtal_run_i, .diff_ref0_true_i,
	.xtal_osc_en_o, .xtal_amp_en_o, .ref_mux_sel_o, .clock_out_true_o, .clock_out_comp_o,
	.clock_out_oe_o, .low_power_diff_drive_o);
`default_nettype wire

// ---- clk_fanout_regs_tb_top.sv ----
// Testbench of the fan-out control block
`timescale 1ns/1ps
`default_nettype none
module clk_fanout_regs_tb_top;
	import clk_fanout_pkg::*;
	logic core_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [2:0] ref_cnt = 3'h0;
	logic otp_run = 1'b1;
	logic reg_wr_i, reg_rd_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
	logic xtal_osc_en_o, xtal_amp_en_o;
	logic [1:0] ref_mux_sel_o;
	logic [11:0] tru, cmp, oe, drv;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	// ----
	// Clock, references, watchdog
	// ----
	always #4 core_clk_i = ~core_clk_i;
	// References at three rates; watchdog far above the run length
	always @(posedge core_clk_i) begin
		ref_cnt <= ref_cnt + 3'h1;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			wrap_up();
		end
	end
	clk_fanout_regs dut (.core_clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
		.reg_wdata_i, .reg_rdata_o, .otp_ref_sel_i(SEL_DIFF1), .otp_xtal_run_i(otp_run),
		.diff_ref0_true_i(ref_cnt[1]), .diff_ref1_true_i(ref_cnt[2]),
		.crystal_in_pin_i(ref_cnt[0]), .xtal_osc_en_o, .xtal_amp_en_o, .ref_mux_sel_o,
		.clock_out_true_o(tru), .clock_out_comp_o(cmp), .clock_out_oe_o(oe),
		.low_power_diff_drive_o(drv));
	host_model hm (.clk_i(core_clk_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
		.rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
	// ----
	// Scenarios
	// ----
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic t_reset();
		hm.rd(REF_SRC_OFS, rv);
		check({4'h0, rv}, {10'h0, SEL_DIFF1});
		hm.rd(ON_LOW_OFS, rv);
		check({3'h0, rv, drv[0]}, {3'h0, ON_RST, 1'b0});
	endtask
	// Upper bits written as ones must read back as zero
	task automatic t_source();
		for (int c = 0; c < 4; c++) begin
			hm.wr(REF_SRC_OFS, {6'h3f, 2'(c)});
			hm.rd(REF_SRC_OFS, rv);
			check({4'h0, rv}, 12'(c));
			repeat (4) @(negedge core_clk_i);
			check({10'h0, ref_mux_sel_o}, 12'(c));
			check({10'h0, xtal_amp_en_o, xtal_osc_en_o}, {10'h0, c != 3, c == 2});
		end
	endtask
	// Every disabled code on the first and the last output
	task automatic t_dis_level();
		for (int c = 0; c < 4; c++) begin
			hm.wr(DIS_LOW_OFS, 8'(c));
			hm.wr(DIS_HIGH_OFS, 8'(c << 6));
			repeat (4) @(negedge core_clk_i);
			check({oe[11], oe[0], cmp[11], cmp[0], tru[11], tru[0]},
				{6'h0, {2{c < 2}}, {2{c == 1}}, 2'b00});
		end
	endtask
	// Enable ignores the high-impedance code, disable restores it
	task automatic t_enable();
		hm.wr(REF_SRC_OFS, {6'h0, SEL_DIFF0});
		hm.set_out(DIS_LOW_OFS, 8'h03, ON_LOW_OFS, 8'h01);
		hm.rd(ON_LOW_OFS, rv);
		check({4'h0, rv}, 12'h001);
		hm.wr(ON_HIGH_OFS, 8'h08);
		repeat (8) @(negedge core_clk_i);
		check({oe[11], oe[0], drv[11], drv[1], drv[0]}, 12'h01d);
		hm.wr(ON_LOW_OFS, 8'h00);
		repeat (8) @(negedge core_clk_i);
		check({oe[0], drv[0]}, 12'h000);
		hm.wr(8'h0a, 8'hff);
		hm.rd(8'h0a, rv);
		check({4'h0, rv}, 12'h000);
	endtask
	// Mid-run reset with the crystal normal-run default cleared
	task automatic t_rerun();
		@(posedge core_clk_i);
		arst_n_i <= 1'b0;
		otp_run <= 1'b0;
		repeat (3) @(negedge core_clk_i);
		check({oe[0], drv[0], xtal_amp_en_o, xtal_osc_en_o}, 12'h008);
		@(posedge core_clk_i);
		arst_n_i <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		hm.rd(ON_LOW_OFS, rv);
		check({4'h0, rv}, {4'h0, ON_RST});
		check({10'h0, xtal_amp_en_o, xtal_osc_en_o}, 12'h003);
		hm.wr(REF_SRC_OFS, {6'h0, SEL_BYPASS});
		repeat (4) @(negedge core_clk_i);
		check({10'h0, xtal_amp_en_o, xtal_osc_en_o}, 12'h000);
	endtask
	initial begin
		repeat (16) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		t_reset();
		t_source();
		t_dis_level();
		t_enable();
		t_rerun();
		wrap_up();
	end
endmodule
`default_nettype wire
